// File: pisg_pkg.sv
// ==========================================================================
// Shared constants for the PWM input stage with shoot-through guard
package pisg_pkg;

    // ======================================================================
    // Clock
    localparam int CLK_MHZ = 25;

    // ======================================================================
    // Dead time choices, in ns, and the derived cycle counts (rounded up)
    localparam int DEAD_SEL_W = 2;
    localparam int DEAD_CNT_W = 6;
    localparam int DEAD_NS0   = 250;
    localparam int DEAD_NS1   = 500;
    localparam int DEAD_NS2   = 1000;
    localparam int DEAD_NS3   = 2000;
    localparam int DEAD_CYC0  = (DEAD_NS0 * CLK_MHZ + 999) / 1000;
    localparam int DEAD_CYC1  = (DEAD_NS1 * CLK_MHZ + 999) / 1000;
    localparam int DEAD_CYC2  = (DEAD_NS2 * CLK_MHZ + 999) / 1000;
    localparam int DEAD_CYC3  = (DEAD_NS3 * CLK_MHZ + 999) / 1000;

    // ======================================================================
    // Input glitch filter default length, in cycles
    localparam int PWM_FILTER_CYCLES = 2;

    // ======================================================================
    // Reset values
    localparam logic RST_PWM_CMD   = 1'b0;
    localparam logic RST_FLAG      = 1'b0;
    localparam logic RST_DEBUG     = 1'b0;

    // ======================================================================
    // Drive state of the command generator
    typedef enum logic [1:0] {
        PISG_OFF,
        PISG_ON,
        PISG_HELD
    } pisg_drive_e;

    // ======================================================================
    // Dead time select to cycle count
    function automatic logic [DEAD_CNT_W-1:0] dead_cycles(
        input logic [DEAD_SEL_W-1:0] sel
    );
        logic [DEAD_CNT_W-1:0] cyc;
        cyc = DEAD_CNT_W'(DEAD_CYC0);
        case (sel)
            2'h0:    cyc = DEAD_CNT_W'(DEAD_CYC0);
            2'h1:    cyc = DEAD_CNT_W'(DEAD_CYC1);
            2'h2:    cyc = DEAD_CNT_W'(DEAD_CYC2);
            2'h3:    cyc = DEAD_CNT_W'(DEAD_CYC3);
            default: cyc = DEAD_CNT_W'(DEAD_CYC0);
        endcase
        return cyc;
    endfunction : dead_cycles

endpackage : pisg_pkg

// File: pisg_dead_timer.sv
`timescale 1ns/1ps
// ==========================================================================
// Dead time extension counter
module pisg_dead_timer #(
    parameter int CNT_W = pisg_pkg::DEAD_CNT_W
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             reload,
    input  wire logic [CNT_W-1:0] loadValue,
    output logic                  busy
);

    generate
        if (CNT_W < 1 || CNT_W > 16) begin : g_bad_width
            $error("pisg_dead_timer: CNT_W out of range");
        end
    endgenerate

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             busy;
    } pisg_timer_s;

    pisg_timer_s st;
    pisg_timer_s next_st;

    // ======================================================================
    // Reload while the monitor is high, count down once it has fallen
    always_comb begin
        next_st = st;
        if (reload) begin
            next_st.count = loadValue;
        end else if (st.count != '0) begin
            next_st.count = st.count - CNT_W'(1);
        end
        next_st.busy = (next_st.count != '0);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign busy = st.busy;

endmodule : pisg_dead_timer

// File: pisg_input_stage.sv
`timescale 1ns/1ps
// ==========================================================================
// PWM input stage with shoot-through guard
//
// Turns the PWM, monitor and enable inputs into turn-on and turn-off
// commands for the secondary side, and keeps the guard status flags.
// Latency from a pwmIn edge to the command is FILTER_CYCLES + 1 clocks;
// the filter trades that delay for immunity to short input glitches.
module pisg_input_stage #(
    parameter int FILTER_CYCLES = pisg_pkg::PWM_FILTER_CYCLES,
    parameter int DEAD_W        = pisg_pkg::DEAD_CNT_W
) (
    input  wire logic                            mclk,
    input  wire logic                            rst_n,
    input  wire logic                            pwmIn,
    input  wire logic                            shootThroughMonitorIn,
    input  wire logic                            enableIn,
    input  wire logic                            debugStrapIn,
    input  wire logic [pisg_pkg::DEAD_SEL_W-1:0] shootThroughDeadTimeSel,
    input  wire logic                            errorClear,
    output logic                                 turnOnCmd,
    output logic                                 turnOffCmd,
    output logic                                 shootThroughActiveFlag,
    output logic                                 shootThroughErrorFlag,
    output logic                                 debugMode
);

    // ======================================================================
    // Elaboration checks
    localparam int FW = (FILTER_CYCLES < 2) ? 1 : $clog2(FILTER_CYCLES + 1);

    generate
        if (FILTER_CYCLES < 1 || FILTER_CYCLES > 255) begin : g_bad_filter
            $error("pisg_input_stage: FILTER_CYCLES out of range");
        end
        if (DEAD_W != pisg_pkg::DEAD_CNT_W) begin : g_bad_dead
            $error("pisg_input_stage: DEAD_W must match the dead time table");
        end
    endgenerate

    localparam logic [FW-1:0] FILTER_LAST = FW'(FILTER_CYCLES - 1);

    // Every dead time entry must fit the timer and last at least one cycle,
    // otherwise the inhibit would end with the monitor pulse
    localparam int DEAD_TABLE [4] = '{
        pisg_pkg::DEAD_CYC0,
        pisg_pkg::DEAD_CYC1,
        pisg_pkg::DEAD_CYC2,
        pisg_pkg::DEAD_CYC3
    };

    generate
        for (genvar i = 0; i < 4; i++) begin : g_dead_chk
            if (DEAD_TABLE[i] < 1 || DEAD_TABLE[i] >= (1 << DEAD_W)) begin : g_bad
                $error("pisg_input_stage: dead time entry out of range");
            end
        end
    endgenerate

    // ======================================================================
    // State
    typedef struct packed {
        pisg_pkg::pisg_drive_e drive;
        logic                  pwmFilt;
        logic [FW-1:0]         filtCnt;
        logic                  strapTaken;
        logic                  debugMode;
        logic                  activeFlag;
        logic                  errorFlag;
        logic                  turnOn;
        logic                  turnOff;
    } pisg_state_s;

    pisg_state_s st;
    pisg_state_s next_st;

    logic              deadBusy;
    logic              inhibitNow;
    logic              enableValid;
    logic              onRequest;
    logic              blockedAgain;
    logic [DEAD_W-1:0] deadLoad;

    // ======================================================================
    // Drive state decode, shared by both command outputs
    function automatic logic isDriveOn(input pisg_pkg::pisg_drive_e d);
        return (d == pisg_pkg::PISG_ON);
    endfunction : isDriveOn

    // ======================================================================
    // Dead time extension
    // The timer reloads for every monitor-high cycle, so the extension
    // is measured from the falling edge of the monitor pulse.
    assign deadLoad = pisg_pkg::dead_cycles(shootThroughDeadTimeSel);

    pisg_dead_timer #(
        .CNT_W     (DEAD_W)
    ) u_dead_timer (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .reload    (shootThroughMonitorIn),
        .loadValue (deadLoad),
        .busy      (deadBusy)
    );

    // Monitor pulse plus dead time
    assign inhibitNow = shootThroughMonitorIn | deadBusy;

    // ======================================================================
    // Request decode
    // The enable pad is pulled low when left open, so an unconnected
    // enable reads as invalid and keeps the switch off.
    assign enableValid = enableIn;

    // Non-inverted drive only: a high filtered level asks for on
    assign onRequest = st.pwmFilt & enableValid;

    // A request still held off at a second sample has been blocked for
    // at least one whole clock period.
    assign blockedAgain = (st.drive == pisg_pkg::PISG_HELD) &
                          onRequest & inhibitNow;

    // ======================================================================
    // Next state
    always_comb begin
        next_st = st;

        // ------------------------------------------------------------------
        // Glitch filter: a new level must persist for FILTER_CYCLES samples.
        // Costs FILTER_CYCLES cycles of latency on every edge of pwmIn.
        if (pwmIn == st.pwmFilt) begin
            next_st.filtCnt = '0;
        end else if (st.filtCnt == FILTER_LAST) begin
            next_st.pwmFilt = pwmIn;
            next_st.filtCnt = '0;
        end else begin
            next_st.filtCnt = st.filtCnt + FW'(1);
        end

        // ------------------------------------------------------------------
        // Debug strap, taken on the first edge after reset release
        if (!st.strapTaken) begin
            next_st.strapTaken = 1'b1;
            next_st.debugMode  = debugStrapIn;
        end

        // ------------------------------------------------------------------
        // Command generator
        case (st.drive)
            pisg_pkg::PISG_OFF: begin
                if (onRequest && !inhibitNow) begin
                    next_st.drive = pisg_pkg::PISG_ON;
                end else if (onRequest) begin
                    // Rising edge caught in the inhibit window
                    next_st.drive = pisg_pkg::PISG_HELD;
                end
            end
            pisg_pkg::PISG_HELD: begin
                if (!onRequest) begin
                    next_st.drive = pisg_pkg::PISG_OFF;
                end else if (!inhibitNow) begin
                    // Short blocks end here as a delayed turn-on only
                    next_st.drive = pisg_pkg::PISG_ON;
                end
            end
            pisg_pkg::PISG_ON: begin
                // Inhibit is not looked at here: an active switch
                // is only ended by pwmIn or by the enable.
                if (!onRequest) begin
                    next_st.drive = pisg_pkg::PISG_OFF;
                end
            end
            default: begin
                next_st.drive = pisg_pkg::PISG_OFF;
            end
        endcase

        // ------------------------------------------------------------------
        // Command outputs, complementary, from the next drive state
        next_st.turnOn  = isDriveOn(next_st.drive);
        next_st.turnOff = !isDriveOn(next_st.drive);

        // ------------------------------------------------------------------
        // Status: same length as the inhibit window, one cycle later
        next_st.activeFlag = inhibitNow;

        // ------------------------------------------------------------------
        // Sticky error; a new block in the clear cycle wins over the clear
        if (blockedAgain) begin
            next_st.errorFlag = 1'b1;
        end else if (errorClear) begin
            next_st.errorFlag = 1'b0;
        end
    end

    // ======================================================================
    // State register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st.drive      <= pisg_pkg::PISG_OFF;
            st.pwmFilt    <= 1'b0;
            st.filtCnt    <= '0;
            st.strapTaken <= 1'b0;
            st.debugMode  <= pisg_pkg::RST_DEBUG;
            st.activeFlag <= pisg_pkg::RST_FLAG;
            st.errorFlag  <= pisg_pkg::RST_FLAG;
            st.turnOn     <= pisg_pkg::RST_PWM_CMD;
            st.turnOff    <= ~pisg_pkg::RST_PWM_CMD;
        end else begin
            st <= next_st;
        end
    end

    // ======================================================================
    // Outputs, each straight from a state flip-flop
    assign turnOnCmd              = st.turnOn;
    assign turnOffCmd             = st.turnOff;
    assign shootThroughActiveFlag = st.activeFlag;
    assign shootThroughErrorFlag  = st.errorFlag;
    assign debugMode              = st.debugMode;

endmodule : pisg_input_stage

// File: pisg_input_stage_props.sv
`timescale 1ns/1ps
// ====================
// Port checks of the input stage
module pisg_input_stage_props (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic pwmIn,
    input wire logic shootThroughMonitorIn,
    input wire logic enableIn,
    input wire logic errorClear,
    input wire logic turnOnCmd,
    input wire logic turnOffCmd,
    input wire logic shootThroughActiveFlag,
    input wire logic shootThroughErrorFlag
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_OFF_PAIR: assert property (turnOffCmd == !turnOnCmd)
        else $error("off command not inverse of on");
    AST_EN_OFF: assert property (!enableIn |=> !turnOnCmd)
        else $error("on command while enable invalid");
    // The input filter lags pwmIn, so the request is looked for two and
    // three samples back rather than at the launching edge
    AST_ON_CAUSE: assert property ($rose(turnOnCmd) |->
        ($past(pwmIn, 2) || $past(pwmIn, 3)) && $past(enableIn))
        else $error("on command without request");
    AST_ON_REQ: assert property ((pwmIn && enableIn &&
        !shootThroughMonitorIn && !shootThroughActiveFlag)[*5] |=> turnOnCmd)
        else $error("on request not served");
    AST_LOW_OFF: assert property (!pwmIn[*4] |=> !turnOnCmd)
        else $error("on command after pwm low");
    AST_NO_RISE: assert property ($rose(turnOnCmd) |->
        !shootThroughActiveFlag)
        else $error("turn on inside inhibit window");
    AST_HOLD_ON: assert property (turnOnCmd && pwmIn &&
        $past(pwmIn) && enableIn |=> turnOnCmd)
        else $error("on command dropped while pwm high");
    AST_MON_FLAG: assert property (shootThroughMonitorIn |=>
        shootThroughActiveFlag)
        else $error("monitor high without active flag");
    AST_ERR_CAUSE: assert property ($rose(shootThroughErrorFlag) |->
        shootThroughActiveFlag)
        else $error("error flag outside inhibit window");
    AST_ERR_KEEP: assert property (shootThroughErrorFlag &&
        !errorClear |=> shootThroughErrorFlag)
        else $error("error flag lost without clear");
endmodule : pisg_input_stage_props

bind pisg_input_stage pisg_input_stage_props u_props (.mclk, .rst_n,
    .pwmIn, .shootThroughMonitorIn, .enableIn, .errorClear, .turnOnCmd,
    .turnOffCmd, .shootThroughActiveFlag, .shootThroughErrorFlag);

// File: pisg_host_model.sv
`timescale 1ns/1ps
// ====================
// Host model: pins follow requests one cycle later; PWM is kept low for
// a while after enable turns valid, as a careful host would do
module pisg_host_model #(
    parameter int EN_DELAY = 8
) (
    input  wire logic mclk,
    input  wire logic reqPwm,
    input  wire logic reqMonitor,
    input  wire logic reqEnable,
    output logic      pwmIn,
    output logic      shootThroughMonitorIn,
    output logic      enableIn
);
    int   holdCnt = 0;
    logic enRise;
    assign enRise = reqEnable & ~enableIn;
    initial {pwmIn, shootThroughMonitorIn, enableIn} = 3'h0;
    always @(negedge mclk) begin
        if (enRise) begin
            holdCnt <= EN_DELAY;
        end else if (holdCnt != 0) begin
            holdCnt <= holdCnt - 1;
        end
        pwmIn                 <= reqPwm && !enRise && holdCnt == 0;
        shootThroughMonitorIn <= reqMonitor;
        enableIn              <= reqEnable;
    end
endmodule : pisg_host_model

// File: pisg_input_stage_test.sv
`timescale 1ns/1ps
// ====================
// Self-checking bench for the input stage
module pisg_input_stage_test;
    localparam int FILT = pisg_pkg::PWM_FILTER_CYCLES;
    localparam int END  = 8;
    // Dead times 250/500/1000/2000 ns in 40 ns cycles, rounded up
    int         deadCyc[4] = '{7, 13, 25, 50};
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic       reqPwm = 1'b0;
    logic       reqMon = 1'b0;
    logic       reqEn = 1'b0;
    logic       strap = 1'b0;
    logic       errClr = 1'b0;
    logic [1:0] sel = 2'h0;
    logic       pwmIn, monIn, enIn, onCmd, offCmd, actFlag, errFlag, dbg;
    int         err_count = 0;
    int         compares = 0;

    always #20 mclk = ~mclk;

    pisg_host_model #(.EN_DELAY(END)) HOST (.mclk(mclk), .reqPwm(reqPwm),
        .reqMonitor(reqMon), .reqEnable(reqEn), .pwmIn(pwmIn),
        .shootThroughMonitorIn(monIn), .enableIn(enIn));

    pisg_input_stage #(.FILTER_CYCLES(FILT)) DUT (.mclk(mclk),
        .rst_n(rst_n), .pwmIn(pwmIn), .shootThroughMonitorIn(monIn),
        .enableIn(enIn), .debugStrapIn(strap),
        .shootThroughDeadTimeSel(sel), .errorClear(errClr),
        .turnOnCmd(onCmd), .turnOffCmd(offCmd),
        .shootThroughActiveFlag(actFlag), .shootThroughErrorFlag(errFlag),
        .debugMode(dbg));

    // ====================
    // Helpers
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick

    // Counts falling edges until the on command reaches the wanted level
    task automatic waitOn(input logic want, output int k);
        for (k = 1; k <= 200; k++) begin
            tick(1);
            if (onCmd === want) return;
        end
        check("on command wait", 8'h0, 8'h1);
        summarize();
    endtask : waitOn

    // ====================
    // Scenarios
    task automatic doReset(input logic s);
        rst_n <= 1'b0;
        strap <= s;
        tick(16);
        rst_n <= 1'b1;
        tick(2);
        strap <= ~s;
        tick(3);
        check("debugMode", dbg, s);
        check("off after reset", offCmd, 1'b1);
        $display("test reset done");
    endtask : doReset

    task automatic testOnOff;
        int k;
        reqEn <= 1'b1;
        tick(END + 4);
        reqPwm <= 1'b1;
        waitOn(1'b1, k);
        check("on latency", 8'(k), 8'(FILT + 2));
        check("off pin while on", offCmd, 1'b0);
        reqPwm <= 1'b0;
        waitOn(1'b0, k);
        check("off latency", 8'(k), 8'(FILT + 2));
        $display("test on_off done");
    endtask : testOnOff

    task automatic testEnable;
        int k;
        reqPwm <= 1'b1;
        waitOn(1'b1, k);
        reqEn <= 1'b0;
        waitOn(1'b0, k);
        check("enable off latency", 8'(k), 8'h2);
        tick(40);
        check("suppressed on", onCmd, 1'b0);
        // PWM must be low when enable turns valid, so drop it first
        reqPwm <= 1'b0;
        tick(FILT + 2);
        check("still off", onCmd, 1'b0);
        reqEn <= 1'b1;
        reqPwm <= 1'b1;
        waitOn(1'b1, k);
        check("restart latency", 8'(k), 8'(END + FILT + 3));
        reqPwm <= 1'b0;
        waitOn(1'b0, k);
        $display("test enable done");
    endtask : testEnable

    task automatic testBlocked;
        int k;
        reqMon <= 1'b1;
        tick(2);
        reqPwm <= 1'b1;
        tick(10);
        check("blocked on", onCmd, 1'b0);
        check("error set", errFlag, 1'b1);
        reqMon <= 1'b0;
        waitOn(1'b1, k);
        check("flag at late on", actFlag, 1'b0);
        check("error kept", errFlag, 1'b1);
        errClr <= 1'b1;
        tick(1);
        errClr <= 1'b0;
        tick(1);
        check("error cleared", errFlag, 1'b0);
        reqPwm <= 1'b0;
        waitOn(1'b0, k);
        $display("test blocked done");
    endtask : testBlocked

    task automatic testStayOn;
        int k;
        reqPwm <= 1'b1;
        waitOn(1'b1, k);
        reqMon <= 1'b1;
        tick(20);
        check("held on", onCmd, 1'b1);
        reqPwm <= 1'b0;
        waitOn(1'b0, k);
        check("off under guard", 8'(k), 8'(FILT + 2));
        check("no error", errFlag, 1'b0);
        reqMon <= 1'b0;
        tick(60);
        $display("test stay_on done");
    endtask : testStayOn

    task automatic testWindow;
        int w;
        for (int s = 0; s < 4; s++) begin
            sel <= 2'(s);
            tick(2);
            reqMon <= 1'b1;
            w = 0;
            for (int i = 0; i < 80; i++) begin
                if (i == 5) reqMon <= 1'b0;
                tick(1);
                if (actFlag === 1'b1) w++;
            end
            check("window width", 8'(w), 8'(5 + deadCyc[s]));
        end
        $display("test window done");
    endtask : testWindow

    initial begin
        doReset(1'b1);
        testOnOff();
        doReset(1'b0);
        testEnable();
        testBlocked();
        testStayOn();
        testWindow();
        summarize();
    end
endmodule : pisg_input_stage_test
